// File: common/sncr_pkg.sv
// package of register numbers, field positions and types for the switch node config bank
package sncr_pkg;

	// register numbers (word index on the configuration port)
	localparam logic [7:0] REG_DEVICE_IDENTIFICATION = 8'h00;
	localparam logic [7:0] REG_SWITCH_DESCRIPTION = 8'h01;
	localparam logic [7:0] REG_SWITCH_CONFIGURATION = 8'h04;
	localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
	localparam logic [7:0] REG_PLL_SETTINGS = 8'h06;
	localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
	localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
	localparam logic [7:0] REG_JTAG_IDENTITY = 8'h09;
	localparam logic [7:0] REG_USER_CODE = 8'h0A;
	localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0C;
	localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0D;

	// switch configuration field positions
	localparam int CFG_CTRL_LOCK_BIT = 31;
	localparam int CFG_PLL_LOCK_BIT = 8;
	localparam int CFG_HEADER_BIT = 0;

	// pll settings field positions
	localparam int PLL_NO_RESET_BIT = 31;
	localparam int PLL_NO_WAIT_BIT = 30;
	localparam int PLL_BYPASS_BIT = 29;
	localparam int PLL_JTAG_BOOT_BIT = 28;
	// writable bits of pll settings: 31:28, 25:23, 20:8, 6:0
	localparam logic [31:0] PLL_WRITE_MASK = 32'hF39FFF7F;

	// reset values
	localparam logic [31:0] PLL_RESET_VALUE = 32'h00000000;
	localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
	localparam logic [15:0] REF_DIV_RESET = 16'h0003;
	localparam logic [15:0] NODE_ID_RESET = 16'h0000;
	localparam logic [31:0] DIRECTIONS_RESET = 32'h00000000;

	// configuration access request
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] number;
		logic [31:0] data;
	} sncr_req_type;

	// routing lookup request
	typedef struct packed {
		logic valid;
		logic [15:0] destination;
	} sncr_route_req_type;

	// routing answer
	typedef struct packed {
		logic valid;
		logic local_hit;
		logic [3:0] direction;
	} sncr_route_ans_type;

endpackage : sncr_pkg

// File: src/sncr_dir_lookup.sv
// priority encoder picking the direction for the most significant mismatching id bit
`timescale 1ns/10ps
`default_nettype none
module sncr_dir_lookup
	import sncr_pkg::*;
(
	// compared identifiers
	input wire logic [15:0] i_destination,
	input wire logic [15:0] i_node_id,
	// direction table, low and high halves
	input wire logic [31:0] i_dir_low,
	input wire logic [31:0] i_dir_high,
	// result
	output logic o_local,
	output logic [3:0] o_direction
);
	logic [15:0] diff; // mismatching bit positions
	logic [63:0] table_all; // directions 15..0 packed

	assign diff = i_destination ^ i_node_id;
	assign table_all = {i_dir_high, i_dir_low};

	// scan upward so the highest mismatch wins
	always_comb begin
		o_local = (diff == 16'h0000);
		o_direction = 4'h0;
		for (int k = 0; k < 16; k++) begin
			if (diff[k]) begin
				o_direction = table_all[4*k +: 4];
			end
		end
	end
endmodule : sncr_dir_lookup
`default_nettype wire

// File: src/sncr_switch_node_config_regs.sv
// switch node configuration register bank with direction table lookup
// Behaviour
// - registers reached by numbered configuration reads/writes
// - identification returns boot pins, revision, version
// - description reports links and processor counts
// - bit31 locks control writes, bit8 locks PLL
// - configuration bit0 selects one or two-byte headers
// - node identifier is writable 16 bits, resets zero
// - any PLL settings write with both locks clear resets the tile
// - PLL bit31 set suppresses that reset
// - PLL bit30 set skips waiting for relock
// - PLL bit29 set bypasses the PLL
// - PLL bit28 set forces JTAG boot mode
// - PLL holds output, feedback, input dividers
// - switch clock divider is 16 writable bits
// - reference divider 16 bits, resets to three
// - user code reads OTP code and metal ID
// - mismatch positions 7..0 use low direction register
// - mismatch positions 15..8 use high direction register
`timescale 1ns/10ps
`default_nettype none
module sncr_switch_node_config_regs
	import sncr_pkg::*;
#(
	// identification values; arbitrary defaults
	parameter logic [7:0] SWITCH_REVISION = 8'h01,
	parameter logic [7:0] SWITCH_VERSION = 8'h01,
	parameter logic [7:0] LINK_COUNT = 8'h08,
	parameter logic [7:0] SWITCH_PROCESSORS = 8'h02,
	parameter logic [7:0] DEVICE_PROCESSORS = 8'h02,
	parameter logic [31:0] JTAG_IDENTITY = 32'h00000001, // arbitrary
	parameter logic [17:0] METAL_ID = 18'h00001 // arbitrary
)(
	// clock, reset, enable
	input wire logic I_CLK_SYS,
	input wire logic I_RESETN,
	input wire logic I_CE,
	// strap levels and otp inputs
	input wire logic [7:0] I_BOOT_CONTROL_PINS,
	input wire logic [13:0] I_OTP_USER_CODE,
	// configuration port
	input wire logic I_CFG_WRITE,
	input wire logic I_CFG_READ,
	input wire logic [7:0] I_CFG_NUMBER,
	input wire logic [31:0] I_CFG_WDATA,
	output logic [31:0] O_CFG_RDATA,
	output logic O_CFG_RVALID,
	// routing lookup
	input wire logic I_ROUTE_VALID,
	input wire logic [15:0] I_ROUTE_DEST,
	output logic O_ROUTE_VALID,
	output logic O_ROUTE_LOCAL,
	output logic [3:0] O_ROUTE_DIRECTION,
	// configuration outputs
	output logic O_HEADER_ONE_BYTE,
	output logic [15:0] O_NODE_ID,
	output logic [31:0] O_PLL_SETTINGS,
	output logic O_PLL_BYPASS,
	output logic O_BOOT_FROM_JTAG,
	output logic O_TILE_RESET,
	output logic O_PLL_WAIT_LOCK,
	output logic [15:0] O_SWITCH_CLOCK_DIVIDER,
	output logic [15:0] O_REFERENCE_CLOCK_DIVIDER
);

	// whole state of the bank
	typedef struct packed {
		logic strap_taken; // boot pins captured after reset
		logic [7:0] boot_pins; // captured strap levels
		logic ctrl_lock; // switch control write lock
		logic pll_lock; // pll settings write lock
		logic header_one; // header mode
		logic [15:0] node_id; // node identifier
		logic [31:0] pll; // pll settings
		logic [15:0] sw_div; // switch clock divider
		logic [15:0] ref_div; // reference clock divider
		logic [31:0] dir_low; // directions 0-7
		logic [31:0] dir_high; // directions 8-15
		logic [31:0] rdata; // read answer
		logic rvalid; // read answer strobe
		logic tile_reset; // tile reset pulse
		logic wait_lock; // pll relock wait pulse
		sncr_route_ans_type route; // routing answer
	} sncr_state_type;

	sncr_state_type state; // registered state
	sncr_state_type next_state; // next state
	sncr_req_type req; // bundled access
	sncr_route_req_type rreq; // bundled lookup
	logic look_local; // lookup result: local delivery
	logic [3:0] look_dir; // lookup result: direction
	logic [31:0] read_mux; // selected register value
	logic wr_ctrl_ok; // write to control registers allowed
	logic wr_pll_ok; // write to pll settings allowed

	assign req = '{write: I_CFG_WRITE, read: I_CFG_READ, number: I_CFG_NUMBER, data: I_CFG_WDATA};
	assign rreq = '{valid: I_ROUTE_VALID, destination: I_ROUTE_DEST};

	// direction table lookup against current node id
	sncr_dir_lookup u_lookup (
		.i_destination(rreq.destination),
		.i_node_id(state.node_id),
		.i_dir_low(state.dir_low),
		.i_dir_high(state.dir_high),
		.o_local(look_local),
		.o_direction(look_dir)
	);

	// read multiplexer; reserved bits and unmapped numbers read zero
	always_comb begin
		case (req.number)
			REG_DEVICE_IDENTIFICATION: begin
				read_mux = {8'h00, state.boot_pins, SWITCH_REVISION, SWITCH_VERSION};
			end
			REG_SWITCH_DESCRIPTION: begin
				read_mux = {8'h00, LINK_COUNT, SWITCH_PROCESSORS, DEVICE_PROCESSORS};
			end
			REG_SWITCH_CONFIGURATION: begin
				read_mux = {state.ctrl_lock, 22'h000000, state.pll_lock, 7'h00, state.header_one};
			end
			REG_NODE_IDENTIFIER: begin
				read_mux = {16'h0000, state.node_id};
			end
			REG_PLL_SETTINGS: begin
				read_mux = state.pll;
			end
			REG_SWITCH_CLOCK_DIVIDER: begin
				read_mux = {16'h0000, state.sw_div};
			end
			REG_REFERENCE_CLOCK_DIVIDER: begin
				read_mux = {16'h0000, state.ref_div};
			end
			REG_JTAG_IDENTITY: begin
				read_mux = JTAG_IDENTITY;
			end
			REG_USER_CODE: begin
				read_mux = {I_OTP_USER_CODE, METAL_ID};
			end
			REG_ROUTE_DIRECTIONS_LOW: begin
				read_mux = state.dir_low;
			end
			REG_ROUTE_DIRECTIONS_HIGH: begin
				read_mux = state.dir_high;
			end
			default: begin
				read_mux = 32'h00000000;
			end
		endcase
	end

	// write permissions from the lock bits
	assign wr_ctrl_ok = req.write && !state.ctrl_lock;
	assign wr_pll_ok = wr_ctrl_ok && !state.pll_lock;

	// next state computation
	always_comb begin
		next_state = state;
		next_state.rvalid = 1'b0;
		next_state.tile_reset = 1'b0;
		next_state.wait_lock = 1'b0;
		// capture strap levels once after reset release
		if (!state.strap_taken) begin
			next_state.strap_taken = 1'b1;
			next_state.boot_pins = I_BOOT_CONTROL_PINS;
		end
		// read answer one cycle after request
		if (req.read) begin
			next_state.rvalid = 1'b1;
			next_state.rdata = read_mux;
		end
		// the configuration register stays writable so the lock can be lifted
		if (req.write && req.number == REG_SWITCH_CONFIGURATION) begin
			next_state.ctrl_lock = req.data[CFG_CTRL_LOCK_BIT];
			next_state.pll_lock = req.data[CFG_PLL_LOCK_BIT];
			next_state.header_one = req.data[CFG_HEADER_BIT];
		end
		// guarded control registers
		if (wr_ctrl_ok) begin
			case (req.number)
				REG_NODE_IDENTIFIER: begin
					next_state.node_id = req.data[15:0];
				end
				REG_SWITCH_CLOCK_DIVIDER: begin
					next_state.sw_div = req.data[15:0];
				end
				REG_REFERENCE_CLOCK_DIVIDER: begin
					next_state.ref_div = req.data[15:0];
				end
				REG_ROUTE_DIRECTIONS_LOW: begin
					next_state.dir_low = req.data;
				end
				REG_ROUTE_DIRECTIONS_HIGH: begin
					next_state.dir_high = req.data;
				end
				default: begin
					next_state.rvalid = next_state.rvalid; // read-only numbers ignore writes
				end
			endcase
		end
		// pll settings write and its side effects
		if (wr_pll_ok && req.number == REG_PLL_SETTINGS) begin
			next_state.pll = req.data & PLL_WRITE_MASK;
			next_state.tile_reset = !req.data[PLL_NO_RESET_BIT];
			next_state.wait_lock = !req.data[PLL_NO_WAIT_BIT];
		end
		// routing answer registered one cycle after request
		next_state.route.valid = rreq.valid;
		if (rreq.valid) begin
			next_state.route.local_hit = look_local;
			next_state.route.direction = look_local ? 4'h0 : look_dir;
		end
	end

	// state register with synchronous reset and clock enable
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESETN) begin
			state <= '0;
			state.ref_div <= REF_DIV_RESET;
			state.sw_div <= SWITCH_DIV_RESET;
			state.node_id <= NODE_ID_RESET;
			state.pll <= PLL_RESET_VALUE;
			state.dir_low <= DIRECTIONS_RESET;
			state.dir_high <= DIRECTIONS_RESET;
		end else if (I_CE) begin
			state <= next_state;
		end
	end

	// outputs straight from state flops
	assign O_CFG_RDATA = state.rdata;
	assign O_CFG_RVALID = state.rvalid;
	assign O_ROUTE_VALID = state.route.valid;
	assign O_ROUTE_LOCAL = state.route.local_hit;
	assign O_ROUTE_DIRECTION = state.route.direction;
	assign O_HEADER_ONE_BYTE = state.header_one;
	assign O_NODE_ID = state.node_id;
	assign O_PLL_SETTINGS = state.pll;
	assign O_PLL_BYPASS = state.pll[PLL_BYPASS_BIT];
	assign O_BOOT_FROM_JTAG = state.pll[PLL_JTAG_BOOT_BIT];
	assign O_TILE_RESET = state.tile_reset;
	assign O_PLL_WAIT_LOCK = state.wait_lock;
	assign O_SWITCH_CLOCK_DIVIDER = state.sw_div;
	assign O_REFERENCE_CLOCK_DIVIDER = state.ref_div;

	// assertions
	chk_ref_reset: assert property (@(posedge I_CLK_SYS)
		$rose(I_RESETN) |-> O_REFERENCE_CLOCK_DIVIDER == 16'h0003)
		else $error("reference divider not three after reset");
	chk_pll_lock_block: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_WRITE && I_CFG_NUMBER == REG_PLL_SETTINGS && state.pll_lock
		|=> $stable(O_PLL_SETTINGS) && !O_TILE_RESET)
		else $error("pll settings changed while locked");
	chk_ctrl_lock_block: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_WRITE && I_CFG_NUMBER == REG_NODE_IDENTIFIER && state.ctrl_lock
		|=> $stable(O_NODE_ID))
		else $error("node id changed while locked");
	chk_tile_reset_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_WRITE && I_CFG_NUMBER == REG_PLL_SETTINGS && !state.pll_lock
		&& !state.ctrl_lock && !I_CFG_WDATA[31] |=> O_TILE_RESET)
		else $error("pll write did not reset tile");
	chk_no_reset_bit: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_WRITE && I_CFG_NUMBER == REG_PLL_SETTINGS && I_CFG_WDATA[31]
		|=> !O_TILE_RESET)
		else $error("tile reset despite suppress bit");
	chk_node_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_WRITE && I_CFG_NUMBER == REG_NODE_IDENTIFIER && !state.ctrl_lock
		|=> O_NODE_ID == $past(I_CFG_WDATA[15:0]))
		else $error("node id write lost");
	chk_read_answer: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_READ && I_CFG_NUMBER == REG_NODE_IDENTIFIER
		|=> O_CFG_RVALID && O_CFG_RDATA == {16'h0000, $past(O_NODE_ID)})
		else $error("node id read wrong");
	chk_route_local: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_ROUTE_VALID && I_ROUTE_DEST == O_NODE_ID |=> O_ROUTE_VALID && O_ROUTE_LOCAL)
		else $error("local packet not delivered locally");
	chk_route_top_bit: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_ROUTE_VALID && (I_ROUTE_DEST[15] != O_NODE_ID[15])
		|=> O_ROUTE_DIRECTION == $past(state.dir_high[31:28]))
		else $error("bit 15 mismatch direction wrong");
	chk_route_bit_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_ROUTE_VALID && ((I_ROUTE_DEST ^ O_NODE_ID) == 16'h0001)
		|=> O_ROUTE_DIRECTION == $past(state.dir_low[3:0]))
		else $error("bit 0 mismatch direction wrong");
	chk_header_mode: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_CFG_WRITE && I_CFG_NUMBER == REG_SWITCH_CONFIGURATION
		|=> O_HEADER_ONE_BYTE == $past(I_CFG_WDATA[0]))
		else $error("header mode not taken");
endmodule : sncr_switch_node_config_regs
`default_nettype wire

// File: dv/sncr_switch_node_config_regs_bench.sv
// self-checking bench for the switch node configuration register bank
`timescale 1ns/10ps
`default_nettype none
module sncr_switch_node_config_regs_bench
	import sncr_pkg::*;
;
	// identification values handed to the bank; arbitrary
	localparam logic [7:0] REV = 8'h5A;
	localparam logic [7:0] VER = 8'h3C;
	localparam logic [7:0] LNK = 8'h04;
	localparam logic [7:0] SPR = 8'h02;
	localparam logic [7:0] DPR = 8'h03;
	localparam logic [31:0] JID = 32'h00000ABD; // arbitrary
	localparam logic [17:0] MID = 18'h25A5A; // arbitrary
	logic clk_sys = 1'b0; // bench clock
	logic resetn = 1'b0; // reset, active low
	logic ce = 1'b1; // clock enable
	logic [7:0] boot_pins = 8'h00; // strap levels
	logic [13:0] otp_code = 14'h0000; // otp user code
	sncr_req_type req = '0; // configuration request
	sncr_route_req_type rreq = '0; // routing request
	logic [31:0] rdata; // read answer
	logic rvalid;
	logic rt_valid;
	logic rt_local;
	logic [3:0] rt_dir;
	logic hdr;
	logic [15:0] node_id;
	logic [31:0] pll;
	logic bypass;
	logic jtag_boot;
	logic tile_rst;
	logic wait_lock;
	logic [15:0] sw_div;
	logic [15:0] ref_div;
	logic [31:0] rd_q[$]; // expected read words
	logic [4:0] rt_q[$]; // expected {local, direction}
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;
	logic [7:0] boot_exp;
	logic [31:0] v;
	logic [63:0] tab;
	logic [15:0] nid;
	logic [15:0] d;

	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	sncr_switch_node_config_regs #(.SWITCH_REVISION(REV), .SWITCH_VERSION(VER),
		.LINK_COUNT(LNK), .SWITCH_PROCESSORS(SPR), .DEVICE_PROCESSORS(DPR),
		.JTAG_IDENTITY(JID), .METAL_ID(MID)) i_dut (
		.I_CLK_SYS(clk_sys), .I_RESETN(resetn), .I_CE(ce),
		.I_BOOT_CONTROL_PINS(boot_pins), .I_OTP_USER_CODE(otp_code),
		.I_CFG_WRITE(req.write), .I_CFG_READ(req.read), .I_CFG_NUMBER(req.number),
		.I_CFG_WDATA(req.data), .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid),
		.I_ROUTE_VALID(rreq.valid), .I_ROUTE_DEST(rreq.destination),
		.O_ROUTE_VALID(rt_valid), .O_ROUTE_LOCAL(rt_local), .O_ROUTE_DIRECTION(rt_dir),
		.O_HEADER_ONE_BYTE(hdr), .O_NODE_ID(node_id), .O_PLL_SETTINGS(pll),
		.O_PLL_BYPASS(bypass), .O_BOOT_FROM_JTAG(jtag_boot), .O_TILE_RESET(tile_rst),
		.O_PLL_WAIT_LOCK(wait_lock), .O_SWITCH_CLOCK_DIVIDER(sw_div),
		.O_REFERENCE_CLOCK_DIVIDER(ref_div));

	// compares one value and counts it
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask : chk

	// one configuration access, strobes stay up until the next call
	task automatic acc(input logic w, input logic r, input logic [7:0] n,
		input logic [31:0] dat, input logic [31:0] e);
		req.write = w;
		req.read = r;
		req.number = n;
		req.data = dat;
		if (r) rd_q.push_back(e);
		@(posedge clk_sys);
		#1;
	endtask : acc

	task automatic wr(input logic [7:0] n, input logic [31:0] dat);
		acc(1'b1, 1'b0, n, dat, 32'h0);
	endtask : wr

	task automatic rd(input logic [7:0] n, input logic [31:0] e);
		acc(1'b0, 1'b1, n, 32'h0, e);
	endtask : rd

	// drops the strobes for one cycle
	task automatic idle();
		acc(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
	endtask : idle

	// one routing lookup, valid stays as given
	task automatic rt(input logic vl, input logic [15:0] dst, input logic [4:0] e);
		rreq.valid = vl;
		rreq.destination = dst;
		if (vl) rt_q.push_back(e);
		@(posedge clk_sys);
		#1;
	endtask : rt

	// ends the run with the counts and the verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// watcher: answers are matched against the oldest note
	always @(negedge clk_sys) begin
		if (rvalid === 1'b1) begin
			if (rd_q.size() == 0) chk("unexpected read answer", 32'h0, 32'h1);
			else chk("read data", rd_q.pop_front(), rdata);
		end
		if (rt_valid === 1'b1) begin
			if (rt_q.size() == 0) chk("unexpected route answer", 32'h0, 32'h1);
			else chk("route answer", {27'h0, rt_q.pop_front()}, {27'h0, rt_local, rt_dir});
		end
	end

	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// main sequence
	initial begin
		void'($urandom(32'h6c1c));
		boot_exp = 8'($urandom());
		boot_pins = boot_exp;
		otp_code = 14'($urandom());
		repeat (10) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		idle();
		idle();
		boot_pins = ~boot_exp; // later strap changes must not show
		chk("ref div reset", 32'h3, {16'h0, ref_div});
		rd(REG_DEVICE_IDENTIFICATION, {8'h00, boot_exp, REV, VER});
		rd(REG_SWITCH_DESCRIPTION, {8'h00, LNK, SPR, DPR});
		rd(REG_SWITCH_CONFIGURATION, 32'h0);
		rd(REG_NODE_IDENTIFIER, 32'h0);
		rd(REG_PLL_SETTINGS, PLL_RESET_VALUE);
		rd(REG_SWITCH_CLOCK_DIVIDER, 32'h0);
		rd(REG_REFERENCE_CLOCK_DIVIDER, 32'h3);
		rd(REG_JTAG_IDENTITY, JID);
		rd(REG_USER_CODE, {otp_code, MID});
		rd(REG_ROUTE_DIRECTIONS_LOW, 32'h0);
		rd(REG_ROUTE_DIRECTIONS_HIGH, 32'h0);
		rd(8'h02, 32'h0);
		rd(8'hFF, 32'h0);
		idle();
		$display("test reset values done");
		// all ones into every place except the locks, pll and jtag identity
		wr(REG_DEVICE_IDENTIFICATION, 32'hFFFFFFFF);
		wr(REG_SWITCH_DESCRIPTION, 32'hFFFFFFFF);
		wr(REG_NODE_IDENTIFIER, 32'hFFFFFFFF);
		wr(REG_SWITCH_CLOCK_DIVIDER, 32'hFFFFFFFF);
		wr(REG_REFERENCE_CLOCK_DIVIDER, 32'hFFFFFFFF);
		wr(REG_USER_CODE, 32'hFFFFFFFF);
		wr(REG_ROUTE_DIRECTIONS_LOW, 32'hFFFFFFFF);
		wr(REG_ROUTE_DIRECTIONS_HIGH, 32'hFFFFFFFF);
		idle();
		chk("node id out", 32'hFFFF, {16'h0, node_id});
		chk("switch div out", 32'hFFFF, {16'h0, sw_div});
		rd(REG_DEVICE_IDENTIFICATION, {8'h00, boot_exp, REV, VER});
		rd(REG_SWITCH_DESCRIPTION, {8'h00, LNK, SPR, DPR});
		rd(REG_NODE_IDENTIFIER, 32'h0000FFFF);
		rd(REG_SWITCH_CLOCK_DIVIDER, 32'h0000FFFF);
		rd(REG_REFERENCE_CLOCK_DIVIDER, 32'h0000FFFF);
		rd(REG_USER_CODE, {otp_code, MID});
		rd(REG_ROUTE_DIRECTIONS_HIGH, 32'hFFFFFFFF);
		idle();
		$display("test write masks done");
		// four combinations of the pll control bits, bits 29:28 always the inverse of bits 31:30
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			v[31:30] = i[1:0];
			v[29:28] = ~i[1:0];
			wr(REG_PLL_SETTINGS, v);
			chk("tile reset", {31'h0, ~v[31]}, {31'h0, tile_rst});
			chk("wait lock", {31'h0, ~v[30]}, {31'h0, wait_lock});
			chk("pll out", v & PLL_WRITE_MASK, pll);
			chk("bypass", {31'h0, v[29]}, {31'h0, bypass});
			chk("jtag boot", {31'h0, v[28]}, {31'h0, jtag_boot});
			rd(REG_PLL_SETTINGS, v & PLL_WRITE_MASK);
			chk("pulses end", 32'h0, {30'h0, tile_rst, wait_lock});
		end
		idle();
		$display("test pll done");
		// both locks, then pll lock only, then unlocked
		wr(REG_SWITCH_CONFIGURATION, 32'hFFFFFFFF);
		chk("header mode", 32'h1, {31'h0, hdr});
		wr(REG_NODE_IDENTIFIER, 32'h00001234);
		wr(REG_PLL_SETTINGS, 32'h0);
		// the pulse would stand only in the cycle right after the write
		chk("locked pll pulse", 32'h0, {31'h0, tile_rst});
		chk("locked pll wait", 32'h0, {31'h0, wait_lock});
		wr(REG_ROUTE_DIRECTIONS_LOW, 32'h0);
		rd(REG_NODE_IDENTIFIER, 32'h0000FFFF);
		rd(REG_ROUTE_DIRECTIONS_LOW, 32'hFFFFFFFF);
		rd(REG_SWITCH_CONFIGURATION, 32'h80000101);
		wr(REG_SWITCH_CONFIGURATION, 32'h00000100);
		wr(REG_NODE_IDENTIFIER, 32'h00001234);
		wr(REG_PLL_SETTINGS, 32'h0);
		chk("pll lock pulse", 32'h0, {31'h0, tile_rst});
		chk("node id accepted", 32'h1234, {16'h0, node_id});
		chk("pll kept", v & PLL_WRITE_MASK, pll);
		wr(REG_SWITCH_CONFIGURATION, 32'h0);
		chk("header two bytes", 32'h0, {31'h0, hdr});
		ce = 1'b0;
		wr(REG_NODE_IDENTIFIER, 32'h00005678);
		ce = 1'b1;
		idle();
		chk("frozen by enable", 32'h1234, {16'h0, node_id});
		$display("test locks done");
		// direction table, one lookup per mismatch position, back to back
		nid = 16'($urandom());
		tab = {$urandom(), $urandom()};
		wr(REG_NODE_IDENTIFIER, {16'h0, nid});
		wr(REG_ROUTE_DIRECTIONS_LOW, tab[31:0]);
		wr(REG_ROUTE_DIRECTIONS_HIGH, tab[63:32]);
		idle();
		for (int k = 0; k < 16; k++) begin
			d = nid ^ (16'h1 << k) ^ (16'($urandom()) & ((16'h1 << k) - 16'h1));
			rt(1'b1, d, {1'b0, tab[k*4 +: 4]});
		end
		rt(1'b1, nid, 5'h10);
		rt(1'b0, 16'h0, 5'h00);
		idle();
		idle();
		chk("notes left", 32'h0, 32'(rd_q.size() + rt_q.size()));
		$display("test routing done");
		print_verdict();
	end
endmodule : sncr_switch_node_config_regs_bench
`default_nettype wire
